// *** src/rxsaf_fifo.sv ***
// Synchronous valid/ready FIFO for the filtered receive path
`timescale 1ns/1ns
`default_nettype none
module rxsaf_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 16
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	assign in_ready = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr_r];

	always_ff @(posedge clock)
	begin
		if (push)
		begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop)
			begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			end
			if (push && !pop)
			begin
				count_r <= count_r + 1'b1;
			end
			else if (pop && !push)
			begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** src/rxsaf_filter.sv ***
// Receive serial address filter, address register access and output bus mapping
`timescale 1ns/1ns
`default_nettype none
module rxsaf_filter
#(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clock,
	input wire logic resetn,
	// Configuration straps
	input wire logic port_timing_select,
	input wire logic fifo_bypass_n,
	input wire logic codec_bypass_n,
	input wire logic char_width_select,
	input wire logic [1:0] rx_discard_select,
	// Host read side
	input wire logic device_select_n,
	input wire logic receiver_reset_n,
	input wire logic rx_read_enable_n,
	input wire logic rx_reserved_status_in,
	input wire logic rx_special_char_flag_in,
	input wire logic [rxsaf_pkg::RXSAF_ADDR_W-1:0] rx_bus_in,
	output logic [rxsaf_pkg::RXSAF_BUS_W-1:0] rx_bus_out,
	output logic rx_bus_oe,
	output logic rx_data_valid,
	// Receive character stream from the decoder
	input wire logic char_valid,
	output logic char_ready,
	input wire logic [rxsaf_pkg::RXSAF_ADDR_W-1:0] char_data,
	input wire logic char_special,
	input wire logic char_is_address,
	input wire logic char_reserved_status,
	input wire logic char_cell_start,
	input wire logic rx_remote_flag,
	// Filter state visible to the system
	output logic [rxsaf_pkg::RXSAF_ADDR_W-1:0] address_value,
	output logic address_unicast,
	output logic filter_passing
);
	import rxsaf_pkg::*;

	localparam int FW = RXSAF_ADDR_W + 3;

	// ------------------------------------------------------------
	// Address register
	// ------------------------------------------------------------
	logic [RXSAF_ADDR_W-1:0] addr_r;
	logic mode_r;
	logic wide;
	logic [RXSAF_ADDR_W-1:0] width_mask;
	logic reg_access;
	logic reg_write;
	logic reg_read;

	assign wide = !char_width_select;
	assign width_mask = wide ? RXSAF_ADDR_RST : RXSAF_ADDR_MASK8;
	assign reg_access = !device_select_n && !receiver_reset_n && !rx_read_enable_n;

	// Direction comes from the reserved status line
	always_comb
	begin
		reg_write = 1'b0;
		reg_read = 1'b0;
		if (reg_access && (rx_reserved_status_in == RXSAF_DIR_WRITE))
		begin
			reg_write = 1'b1;
		end
		else if (reg_access)
		begin
			reg_read = 1'b1;
		end
	end

	// Reset pair arrives here as resetn; restores promiscuous value
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			addr_r <= RXSAF_ADDR_RST;
		end
		else if (reg_write)
		begin
			addr_r <= rx_bus_in & width_mask;
		end
	end

	// Mode bit kept apart so a read never disturbs it
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			mode_r <= RXSAF_MODE_MULTI;
		end
		else if (reg_write)
		begin
			mode_r <= rx_special_char_flag_in;
		end
	end

	assign address_value = addr_r;
	assign address_unicast = mode_r;

	// ------------------------------------------------------------
	// Match logic
	// ------------------------------------------------------------
	logic filter_on;
	logic promiscuous;
	logic addr_match;
	logic [RXSAF_ADDR_W-1:0] rx_masked;
	logic [RXSAF_ADDR_W-1:0] reg_masked;
	logic [RXSAF_ADDR_W-1:0] domain_hit;

	// Policy 0 or a bypassed FIFO turns filtering off entirely
	assign filter_on = !port_timing_select && fifo_bypass_n
		&& (rx_discard_select != RXSAF_POL_KEEP);
	assign reg_masked = addr_r & width_mask;
	assign rx_masked = char_data & width_mask;
	// Unicast all-ones is an ordinary address, not promiscuous
	assign promiscuous = (mode_r == RXSAF_MODE_MULTI) && (reg_masked == width_mask);

	// One register bit per domain; bits above the width are masked
	genvar gi;
	generate
		for (gi = 0; gi < RXSAF_ADDR_W; gi++)
		begin : g_domain
			assign domain_hit[gi] = rx_masked[gi] && reg_masked[gi];
		end
	endgenerate

	always_comb
	begin
		if (mode_r == RXSAF_MODE_UNI)
		begin
			addr_match = (rx_masked == reg_masked);
		end
		else
		begin
			addr_match = (domain_hit != '0) || promiscuous;
		end
	end

	// ------------------------------------------------------------
	// Pass / block state
	// ------------------------------------------------------------
	rxsaf_state_e state_r;
	rxsaf_state_e state_nxt;
	logic take;
	logic write_char;

	// Only address characters move the state; data never does
	assign take = char_valid && char_ready;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			RXSAF_ST_PASS:
			begin
				if (take && char_is_address && !addr_match)
				begin
					state_nxt = RXSAF_ST_BLOCK;
				end
			end
			RXSAF_ST_BLOCK:
			begin
				if (take && char_is_address && addr_match)
				begin
					state_nxt = RXSAF_ST_PASS;
				end
			end
			default:
			begin
				state_nxt = RXSAF_ST_PASS;
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			state_r <= RXSAF_ST_PASS;
		end
		else if (!filter_on || promiscuous)
		begin
			state_r <= RXSAF_ST_PASS;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	assign filter_passing = (state_r == RXSAF_ST_PASS);

	// Address itself follows the new decision; policy 3 drops it
	always_comb
	begin
		if (!filter_on)
		begin
			write_char = 1'b1;
		end
		else if (char_is_address)
		begin
			write_char = addr_match
				&& (rx_discard_select != RXSAF_POL_NO_ADDR);
		end
		else
		begin
			write_char = (state_r == RXSAF_ST_PASS) || promiscuous;
		end
	end

	// ------------------------------------------------------------
	// Receive FIFO
	// ------------------------------------------------------------
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [FW-1:0] fifo_out;

	// Limitation: a full FIFO stalls kept characters at the source
	// Dropped characters are consumed without stalling the source
	assign char_ready = fifo_in_ready || !write_char;

	rxsaf_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.resetn(resetn),
		.in_valid(char_valid && write_char),
		.in_ready(fifo_in_ready),
		.in_data({char_cell_start, char_reserved_status, char_special, char_data}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out)
	);

	// ------------------------------------------------------------
	// Read port: select sampled one cycle, read enable the next
	// ------------------------------------------------------------
	logic selected_r;
	logic fifo_read;
	logic [RXSAF_BUS_W-1:0] bus_r;
	logic oe_r;
	logic valid_r;
	logic [RXSAF_BUS_W-1:0] mapped;
	logic [RXSAF_ADDR_W-1:0] fd;

	assign fd = fifo_out[RXSAF_ADDR_W-1:0];

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			selected_r <= 1'b0;
		end
		else
		begin
			selected_r <= !device_select_n;
		end
	end

	assign fifo_read = selected_r && !rx_read_enable_n && receiver_reset_n;
	assign fifo_pop = fifo_read && fifo_out_valid;

	// Undecoded modes pass bits in arrival order, bit 0 first
	always_comb
	begin
		mapped = '0;
		if (codec_bypass_n && !wide)
		begin
			mapped[7:0] = fd[7:0];
			mapped[RXSAF_BIT_FLAG8] = rx_remote_flag;
			mapped[RXSAF_BIT_RVS] = fifo_out[RXSAF_ADDR_W+1];
			mapped[RXSAF_BIT_SOC] = fifo_out[RXSAF_ADDR_W+2];
		end
		else if (codec_bypass_n)
		begin
			mapped[RXSAF_ADDR_W-1:0] = fd;
			mapped[RXSAF_BIT_RVS] = fifo_out[RXSAF_ADDR_W+1];
			mapped[RXSAF_BIT_SOC] = fifo_out[RXSAF_ADDR_W+2];
		end
		else if (!wide)
		begin
			mapped[RXSAF_ADDR_W-1:0] = fd;
		end
		else
		begin
			mapped = fifo_out[RXSAF_BUS_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// Output register
	// ------------------------------------------------------------
	// Trade-off: a register read wins over a FIFO pop in one cycle
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			bus_r <= '0;
		end
		else if (reg_read)
		begin
			bus_r <= {2'b00, addr_r & width_mask};
		end
		else if (fifo_read)
		begin
			bus_r <= mapped;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			oe_r <= 1'b0;
		end
		else
		begin
			oe_r <= reg_read || fifo_read;
		end
	end

	// Valid on a register read or when a word really left the FIFO
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			valid_r <= 1'b0;
		end
		else
		begin
			valid_r <= reg_read || (fifo_read && fifo_out_valid);
		end
	end

	assign rx_bus_out = bus_r;
	assign rx_bus_oe = oe_r;
	assign rx_data_valid = valid_r;
endmodule
`default_nettype wire

// *** src/rxsaf_pkg.sv ***
// Constants and types for the receive serial address filter
// How it works
// - Filtering acts only when port timing select is low (UTOPIA model).
// - Address register is 8 or 10 bits wide, following character width.
// - Multicast: each bit is one domain; any shared domain bit matches.
// - Unicast: whole character must equal register contents to match.
// - On match, address and following data go to FIFO; policy 3 drops address.
// - Writes continue until a non-matching address, then FIFO writes are inhibited.
// - Reset default is multicast, all ones (ff or 3ff).
// - All-ones multicast field accepts every data character and, except under policy 3, every address.
// - Reset pin pair restores the all-ones promiscuous address.
// - Filtering only with FIFO enabled and discard policy not zero.
// - Reserved status picks read/write; special flag picks multicast/unicast.
// - Register sits on rx bus, LSB on bit 0, MSB on bit 7 or 9.
// - Output bus mapped by codec bypass and width select.
// - Undecoded modes: bit 0 is first bit shifted in, rest in arrival order.
// - Data outputs drive when read enable follows cycle with select sampled low.
package rxsaf_pkg;
	localparam int RXSAF_ADDR_W = 10;
	localparam int RXSAF_BUS_W = 12;
	localparam logic [9:0] RXSAF_ADDR_RST = 10'h3ff;
	localparam logic [9:0] RXSAF_ADDR_MASK8 = 10'h0ff;
	localparam logic RXSAF_MODE_MULTI = 1'b0;
	localparam logic RXSAF_MODE_UNI = 1'b1;
	localparam logic RXSAF_DIR_WRITE = 1'b0;
	localparam int RXSAF_BIT_FLAG8 = 8;
	localparam int RXSAF_BIT_RVS = 10;
	localparam int RXSAF_BIT_SOC = 11;
	typedef enum logic [1:0] {
		RXSAF_POL_KEEP = 2'b00,
		RXSAF_POL_LAST_FILL = 2'b01,
		RXSAF_POL_NO_FILL = 2'b10,
		RXSAF_POL_NO_ADDR = 2'b11
	} rxsaf_policy_e;
	typedef enum logic [0:0] {
		RXSAF_ST_PASS = 1'b0,
		RXSAF_ST_BLOCK = 1'b1
	} rxsaf_state_e;
endpackage

// *** testbench/rxsaf_filter_bench.sv ***
// Self-checking bench for the receive serial address filter
`timescale 1ns/1ns
`default_nettype none
module rxsaf_filter_bench;
	import rxsaf_pkg::*;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic width8 = 1'b0;
	logic [1:0] discard = 2'b01;
	logic char_valid = 1'b0;
	logic [9:0] char_data = 10'h000;
	logic is_addr = 1'b0;
	logic remote = 1'b0;
	logic timing_sel = 1'b0;
	logic fifo_on = 1'b1;
	logic codec_on = 1'b1;
	logic sel_n, rr_n, re_n, rvs, flag, oe, dv, ready, uni, passing;
	logic [9:0] bus_in, addr;
	logic [11:0] bus_out;
	logic [11:0] q[$];
	int bad_count = 0;
	int tests_run = 0;
	always #20 clock = ~clock;
	rxsaf_host host (.clock(clock), .device_select_n(sel_n), .receiver_reset_n(rr_n), .rx_read_enable_n(re_n),
		.rvs(rvs), .flag(flag), .bus(bus_in));
	rxsaf_filter #(.FIFO_DEPTH(16)) u_dut (.clock(clock), .resetn(resetn), .port_timing_select(timing_sel),
		.fifo_bypass_n(fifo_on), .codec_bypass_n(codec_on), .char_width_select(width8), .rx_discard_select(discard),
		.device_select_n(sel_n), .receiver_reset_n(rr_n), .rx_read_enable_n(re_n), .rx_reserved_status_in(rvs),
		.rx_special_char_flag_in(flag), .rx_bus_in(bus_in), .rx_bus_out(bus_out), .rx_bus_oe(oe),
		.rx_data_valid(dv), .char_valid(char_valid), .char_ready(ready), .char_data(char_data),
		.char_special(1'b0), .char_is_address(is_addr), .char_reserved_status(char_data[0]),
		.char_cell_start(char_data[1]), .rx_remote_flag(remote), .address_value(addr),
		.address_unicast(uni), .filter_passing(passing));
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic push(input logic [9:0] d, input logic a, output logic ok);
		char_data = d;
		is_addr = a;
		char_valid = 1'b1;
		#1;
		ok = ready;
		host.step();
		char_valid = 1'b0;
		char_data = ~d;
		host.step();
	endtask
	task automatic send(input logic [9:0] d, input logic a, input logic keep);
		logic ok;
		push(d, a, ok);
		if (keep)
			q.push_back({d[1], d[0], d});
	endtask
	task automatic drain();
		while (q.size() > 0)
		begin
			host.fifo_read();
			chk({dv, oe}, 12'h003);
			chk(bus_out, q.pop_front());
		end
		host.fifo_read();
		chk(dv, 1'b0);
	endtask
	task automatic summarize();
		$display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic t_fill();
		logic ok;
		int n;
		logic [9:0] d;
		n = 0;
		ok = 1'b1;
		chk({uni, addr}, {1'b0, RXSAF_ADDR_RST});
		host.reg_access(1'b1, 1'b0, 10'h000);
		chk(bus_out, {2'b00, RXSAF_ADDR_RST});
		while (ok && n < 40)
		begin
			d = 10'h155 + n[9:0];
			push(d, n == 0, ok);
			if (ok)
			begin
				q.push_back({d[1], d[0], d});
				n++;
			end
		end
		chk(n[11:0], 12'd16);
		drain();
		$display("fill done");
	endtask
	task automatic t_filter();
		host.reg_access(1'b0, 1'b1, 10'h2a5);
		chk(uni, 1'b1);
		host.reg_access(1'b1, 1'b1, 10'h000);
		chk(bus_out, 12'h2a5);
		send(10'h2a5, 1'b1, 1'b1);
		send(10'h001, 1'b0, 1'b1);
		send(10'h3c3, 1'b1, 1'b0);
		send(10'h002, 1'b0, 1'b0);
		send(10'h2a5, 1'b1, 1'b1);
		send(10'h003, 1'b0, 1'b1);
		drain();
		discard = 2'b11;
		send(10'h2a5, 1'b1, 1'b0);
		send(10'h004, 1'b0, 1'b1);
		drain();
		discard = 2'b01;
		host.reg_access(1'b0, 1'b0, 10'h012);
		send(10'h002, 1'b1, 1'b1);
		send(10'h005, 1'b0, 1'b1);
		send(10'h100, 1'b1, 1'b0);
		send(10'h006, 1'b0, 1'b0);
		drain();
		$display("filter done");
	endtask
	task automatic t_modes();
		logic ok;
		discard = 2'b00;
		send(10'h100, 1'b1, 1'b1);
		send(10'h007, 1'b0, 1'b1);
		drain();
		resetn = 1'b0;
		repeat (5) host.step();
		resetn = 1'b1;
		chk({uni, addr}, {1'b0, RXSAF_ADDR_RST});
		width8 = 1'b1;
		remote = 1'b1;
		push(10'h0ab, 1'b0, ok);
		q.push_back(12'hdab);
		drain();
		$display("modes done");
	endtask
	task automatic t_bypass();
		logic ok;
		discard = 2'b01;
		width8 = 1'b0;
		host.reg_access(1'b0, 1'b1, 10'h011);
		timing_sel = 1'b1;
		send(10'h022, 1'b1, 1'b1);
		send(10'h008, 1'b0, 1'b1);
		timing_sel = 1'b0;
		fifo_on = 1'b0;
		send(10'h033, 1'b1, 1'b1);
		send(10'h009, 1'b0, 1'b1);
		fifo_on = 1'b1;
		send(10'h044, 1'b1, 1'b0);
		send(10'h00a, 1'b0, 1'b0);
		drain();
		discard = 2'b00;
		codec_on = 1'b0;
		width8 = 1'b1;
		push(10'h2a5, 1'b0, ok);
		q.push_back(12'h2a5);
		drain();
		width8 = 1'b0;
		push(10'h2c7, 1'b0, ok);
		q.push_back(12'hac7);
		drain();
		codec_on = 1'b1;
		$display("bypass done");
	endtask
	initial
	begin
		repeat (5) @(posedge clock);
		#1;
		resetn = 1'b1;
		t_fill();
		t_filter();
		t_modes();
		t_bypass();
		summarize();
	end
	initial
	begin
		repeat (5000) @(posedge clock);
		bad_count++;
		summarize();
	end
endmodule
`default_nettype wire

// *** testbench/rxsaf_filter_monitor.sv ***
// Port checker for the receive serial address filter
`timescale 1ns/1ns
`default_nettype none
module rxsaf_filter_chk
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic port_timing_select,
	input wire logic fifo_bypass_n,
	input wire logic char_width_select,
	input wire logic [1:0] rx_discard_select,
	input wire logic device_select_n,
	input wire logic receiver_reset_n,
	input wire logic rx_read_enable_n,
	input wire logic rx_reserved_status_in,
	input wire logic rx_special_char_flag_in,
	input wire logic [rxsaf_pkg::RXSAF_ADDR_W-1:0] rx_bus_in,
	input wire logic [rxsaf_pkg::RXSAF_BUS_W-1:0] rx_bus_out,
	input wire logic rx_bus_oe,
	input wire logic rx_data_valid,
	input wire logic char_valid,
	input wire logic char_ready,
	input wire logic [rxsaf_pkg::RXSAF_ADDR_W-1:0] char_data,
	input wire logic char_is_address,
	input wire logic [rxsaf_pkg::RXSAF_ADDR_W-1:0] address_value,
	input wire logic address_unicast,
	input wire logic filter_passing
);
	import rxsaf_pkg::*;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);
	logic acc;
	logic act;
	assign acc = !device_select_n && !receiver_reset_n && !rx_read_enable_n;
	// Only 10-bit chars: the 8-bit compare width is checked neither here nor by the bench
	assign act = !port_timing_select && fifo_bypass_n && rx_discard_select != 2'b00 && !char_width_select;
	sequence s_addr;
		act && char_valid && char_ready && char_is_address;
	endsequence
	sequence s_uni(logic hit);
		s_addr ##0 address_unicast && ((char_data == address_value) == hit);
	endsequence
	sequence s_multi(logic hit);
		s_addr ##0 !address_unicast && (((char_data & address_value) != 0) == hit);
	endsequence
	a_reset_default:
	assert property (disable iff (1'b0) !resetn |=> address_value == RXSAF_ADDR_RST && !address_unicast)
		else $error("address not restored by reset");
	a_write_stores:
	assert property (acc && !rx_reserved_status_in |=> address_value[7:0] == $past(rx_bus_in[7:0])
		&& address_unicast == $past(rx_special_char_flag_in)) else $error("write not stored");
	a_read_returns:
	assert property (acc && rx_reserved_status_in |=> rx_bus_oe && rx_data_valid
		&& rx_bus_out[7:0] == $past(address_value[7:0])) else $error("read data wrong");
	a_oe_cause:
	assert property (rx_bus_oe |-> $past(rx_read_enable_n) == 1'b0) else $error("bus driven without read");
	a_uni_match:
	assert property (s_uni(1'b1) |=> filter_passing) else $error("unicast match not passing");
	a_uni_miss:
	assert property (s_uni(1'b0) |=> !filter_passing) else $error("unicast miss not blocking");
	a_multi_hit:
	assert property (s_multi(1'b1) |=> filter_passing) else $error("domain hit not passing");
	a_filter_off:
	assert property (port_timing_select || !fifo_bypass_n || rx_discard_select == 2'b00 |=> filter_passing)
		else $error("filter active while disabled");
	a_multi_miss:
	assert property (s_multi(1'b0) ##0 address_value != RXSAF_ADDR_RST |=> !filter_passing)
		else $error("domain miss not blocking");
endmodule
bind rxsaf_filter rxsaf_filter_chk u_chk (.clock(clock), .resetn(resetn), .port_timing_select(port_timing_select),
	.fifo_bypass_n(fifo_bypass_n), .char_width_select(char_width_select), .rx_discard_select(rx_discard_select),
	.device_select_n(device_select_n), .receiver_reset_n(receiver_reset_n), .rx_read_enable_n(rx_read_enable_n),
	.rx_reserved_status_in(rx_reserved_status_in), .rx_special_char_flag_in(rx_special_char_flag_in),
	.rx_bus_in(rx_bus_in), .rx_bus_out(rx_bus_out), .rx_bus_oe(rx_bus_oe), .rx_data_valid(rx_data_valid),
	.char_valid(char_valid), .char_ready(char_ready), .char_data(char_data), .char_is_address(char_is_address),
	.address_value(address_value), .address_unicast(address_unicast), .filter_passing(filter_passing));
`default_nettype wire

// *** testbench/rxsaf_host.sv ***
// Host controller model for register access and FIFO reads
`timescale 1ns/1ns
`default_nettype none
module rxsaf_host
(
	input wire logic clock,
	output logic device_select_n,
	output logic receiver_reset_n,
	output logic rx_read_enable_n,
	output logic rvs,
	output logic flag,
	output logic [rxsaf_pkg::RXSAF_ADDR_W-1:0] bus
);
	import rxsaf_pkg::*;
	initial
	begin
		{device_select_n, receiver_reset_n, rx_read_enable_n, rvs, flag} = 5'h1f;
		bus = 10'h000;
	end
	task automatic step();
		@(posedge clock);
		#1;
	endtask
	// Control lines are released high and the bus flips so a stale value is never read as good
	task automatic idle();
		{device_select_n, receiver_reset_n, rx_read_enable_n} = 3'h7;
		bus = ~bus;
	endtask
	task automatic reg_access(input logic rd, input logic uni, input logic [RXSAF_ADDR_W-1:0] d);
		step();
		{device_select_n, receiver_reset_n, rx_read_enable_n} = 3'h0;
		rvs = rd;
		flag = uni;
		bus = d;
		step();
		idle();
	endtask
	task automatic fifo_read();
		step();
		device_select_n = 1'b0;
		step();
		rx_read_enable_n = 1'b0;
		step();
		idle();
	endtask
endmodule
`default_nettype wire
